//--- lps_regs.svh
// constants of the schedule master: identifiers, lengths, timing
`ifndef LPS_REGS_SVH
`define LPS_REGS_SVH
`define LPS_CLK_NS      50
`define LPS_TICK_NS     1000000
`define LPS_ID_DIAG_REQ 6'h3C
`define LPS_ID_DIAG_RSP 6'h3D
`define LPS_ID_RSV_HI   5'h1F
`define LPS_DIAG_LEN    4'h8
`define LPS_MIN_SLOT    8'h01
`define LPS_LAST_IDX    3'h7
`define LPS_FIRST_IDX   3'h0
`define LPS_BYTE_ZERO   8'h00
`endif

//--- lps_pkg.sv
// types shared by the schedule master and its entry memory
package lps_pkg;
  typedef struct packed {
    logic       last;
    logic       pub;
    logic [3:0] len;
    logic [5:0] id;
    logic [7:0] dly;
  } lps_entry_type;

  typedef struct packed {
    logic       classic;
    logic [3:0] len;
    logic       pub;
    logic [7:0] pid;
  } lps_hdr_type;

  typedef enum logic [2:0] {LPS_IDLE, LPS_FETCH, LPS_WAIT, LPS_ISSUE, LPS_SLOT} lps_state_type;
endpackage

//--- lps_mem_if.sv
// read port between the sequencer and the entry memory
`timescale 1ns/100ps
interface lps_mem_if;
  import lps_pkg::*;
  logic          rd_en;
  logic [3:0]    rd_addr;
  lps_entry_type rd_data;
  modport master (output rd_en, output rd_addr, input rd_data);
  modport mem    (input rd_en, input rd_addr, output rd_data);
endinterface

//--- lps_entry_mem.sv
// two schedule tables of eight entries, registered read
`timescale 1ns/100ps
module lps_entry_mem
  import lps_pkg::*;
(
  input  wire logic          clk_i,     // system clock
  input  wire logic          reset_n_i, // async reset, low
  input  wire logic          we_i,      // write strobe
  input  wire logic [3:0]    waddr_i,   // {table, index}
  input  wire lps_entry_type wdata_i,   // entry to store
  lps_mem_if.mem             rd         // read port
);
  typedef struct packed {
    lps_entry_type rd_data;
  } lps_mem_state_type;

  lps_entry_type     mem [16];
  lps_mem_state_type s;
  lps_mem_state_type next_s;

  always_comb begin
    next_s = s;
    if (rd.rd_en) begin
      next_s.rd_data = mem[rd.rd_addr];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  assign rd.rd_data = s.rd_data;
endmodule

//--- lps_schedule_master.sv
// schedule master: runs the active table and issues frame headers
//
// Notes on behaviour
// - every header carries one eight-bit protected identifier byte.
// - bit 6 is XOR of id bits 0,1,2,4; bit 7 inverted XOR of 1,3,4,5.
// - the low six bits hold the frame identifier, 0 to 63.
// - 0x3C is the diagnostic request, 0x3D the diagnostic response.
// - 0x3E and 0x3F are reserved and never issued.
// - one table is active; its entries run in their stored order.
// - each issued entry gets its delay, at least one tick, as bus time before the next; reserved ones get none.
// - master sends only the header; data only when it publishes.
// - only the master switches tables, at the end of a table.
// - diagnostic frames always carry eight data bytes.
// - diagnostic frames always use the classic checksum.
// - longer diagnostic payloads span several consecutive eight-byte frames; the master issues one frame per table entry and splits no payload.
`timescale 1ns/100ps
`include "lps_regs.svh"
module lps_schedule_master
  import lps_pkg::*;
#(
  parameter int TICK_CYCLES = `LPS_TICK_NS / `LPS_CLK_NS
)(
  input  wire logic          clk_i,           // 20 MHz clock
  input  wire logic          reset_n_i,       // async reset, low
  input  wire logic          run_i,           // run the schedule
  input  wire logic          table_sel_i,     // table wanted next
  input  wire logic          enhanced_i,      // enhanced checksum for app frames
  input  wire logic          cfg_we_i,        // entry write strobe
  input  wire logic [3:0]    cfg_addr_i,      // {table, index}
  input  wire lps_entry_type cfg_data_i,      // entry to store
  input  wire logic          hdr_ready_i,     // header taken
  output logic               hdr_valid_o,     // header waiting
  output logic [7:0]         hdr_pid_o,       // protected identifier
  output logic [3:0]         hdr_len_o,       // data byte count
  output logic               hdr_pub_o,       // master publishes data
  output logic               hdr_classic_o,   // classic checksum
  input  wire logic          rx_valid_i,      // data byte strobe
  input  wire logic          rx_first_i,      // first byte of frame
  input  wire logic [7:0]    rx_byte_i,       // data byte
  output logic [7:0]         cks_o,           // running checksum
  output logic               active_table_o,  // active table
  output logic [2:0]         entry_idx_o,     // current entry
  output logic               reserved_skip_o  // reserved id skipped
);
  typedef struct packed {
    lps_state_type state;
    logic          tbl;
    logic [2:0]    idx;
    lps_entry_type ent;
    logic [15:0]   tick_cnt;
    logic [7:0]    slot;
    lps_hdr_type   b0;
    logic          v0;
    lps_hdr_type   b1;
    logic          v1;
    logic [7:0]    cur_pid;
    logic          cur_classic;
    logic [7:0]    acc;
    logic [7:0]    cks;
    logic          skip;
  } lps_main_state_type;

  lps_main_state_type s;
  lps_main_state_type next_s;
  lps_mem_if          mif ();

  function automatic logic [7:0] pid_of(input logic [5:0] id);
    pid_of = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
  endfunction

  function automatic logic [7:0] add_carry(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    add_carry = sum[7:0] + {7'h00, sum[8]};
  endfunction

  function automatic logic is_diag(input logic [5:0] id);
    is_diag = (id == `LPS_ID_DIAG_REQ) || (id == `LPS_ID_DIAG_RSP);
  endfunction

  lps_entry_mem u_mem (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .we_i      (cfg_we_i),
    .waddr_i   (cfg_addr_i),
    .wdata_i   (cfg_data_i),
    .rd        (mif.mem)
  );

  assign mif.rd_en   = (s.state == LPS_FETCH);
  assign mif.rd_addr = {s.tbl, s.idx};

  logic        tick;
  logic        advance;
  lps_hdr_type hdr;

  always_comb begin
    next_s  = s;
    tick    = (s.tick_cnt == 16'(TICK_CYCLES - 1));
    advance = 1'b0;
    next_s.skip = 1'b0;
    hdr.pid     = pid_of(s.ent.id);
    hdr.len     = is_diag(s.ent.id) ? `LPS_DIAG_LEN : s.ent.len;
    hdr.classic = is_diag(s.ent.id) ? 1'b1 : ~enhanced_i;
    // request published by master, response by the addressed slave
    hdr.pub = is_diag(s.ent.id) ? (s.ent.id == `LPS_ID_DIAG_REQ) : s.ent.pub;
    if (s.v0 && hdr_ready_i) begin
      next_s.cur_pid     = s.b0.pid;
      next_s.cur_classic = s.b0.classic;
      next_s.b0 = s.b1;
      next_s.v0 = s.v1;
      next_s.v1 = 1'b0;
    end
    unique case (s.state)
      LPS_IDLE: begin
        if (run_i) begin
          next_s.tbl   = table_sel_i;
          next_s.idx   = `LPS_FIRST_IDX;
          next_s.state = LPS_FETCH;
        end
      end
      LPS_FETCH: next_s.state = LPS_WAIT;
      LPS_WAIT: begin
        next_s.ent   = mif.rd_data;
        next_s.state = LPS_ISSUE;
      end
      LPS_ISSUE: begin
        if (s.ent.id[5:1] == `LPS_ID_RSV_HI) begin
          next_s.skip = 1'b1;
          advance     = 1'b1;
        end else if (!s.v1) begin
          if (!next_s.v0) begin
            next_s.b0 = hdr;
            next_s.v0 = 1'b1;
          end else begin
            next_s.b1 = hdr;
            next_s.v1 = 1'b1;
          end
          next_s.tick_cnt = '0;
          next_s.slot  = (s.ent.dly < `LPS_MIN_SLOT) ? `LPS_MIN_SLOT : s.ent.dly;
          next_s.state = LPS_SLOT;
        end
      end
      LPS_SLOT: begin
        next_s.tick_cnt = tick ? '0 : s.tick_cnt + 16'h0001;
        if (tick) begin
          if (s.slot == `LPS_MIN_SLOT) begin
            advance = 1'b1;
          end else begin
            next_s.slot = s.slot - `LPS_MIN_SLOT;
          end
        end
      end
    endcase
    if (advance) begin
      if (s.ent.last || (s.idx == `LPS_LAST_IDX)) begin
        next_s.idx = `LPS_FIRST_IDX;
        next_s.tbl = table_sel_i;
      end else begin
        next_s.idx = s.idx + 3'h1;
      end
      next_s.state = run_i ? LPS_FETCH : LPS_IDLE;
    end
    if (rx_valid_i) begin
      // enhanced frames seed with the identifier, classic with zero
      next_s.acc = add_carry(rx_first_i ? (next_s.cur_classic ? `LPS_BYTE_ZERO : next_s.cur_pid) : s.acc,
                             rx_byte_i);
      next_s.cks = ~next_s.acc;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign hdr_valid_o     = s.v0;
  assign hdr_pid_o       = s.b0.pid;
  assign hdr_len_o       = s.b0.len;
  assign hdr_pub_o       = s.b0.pub;
  assign hdr_classic_o   = s.b0.classic;
  assign cks_o           = s.cks;
  assign active_table_o  = s.tbl;
  assign entry_idx_o     = s.idx;
  assign reserved_skip_o = s.skip;

  // cycles spent in the current slot, for checking only
  logic [31:0] slot_cycles;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slot_cycles <= '0;
    end else begin
      slot_cycles <= (s.state == LPS_SLOT) ? slot_cycles + 32'h1 : '0;
    end
  end
  logic [7:0] slot_len;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slot_len <= '0;
    end else if (s.state == LPS_ISSUE) begin
      slot_len <= next_s.slot;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  pid_parity_a: assert property (hdr_valid_o |->
    hdr_pid_o[6] == (hdr_pid_o[0] ^ hdr_pid_o[1] ^ hdr_pid_o[2] ^ hdr_pid_o[4]) &&
    hdr_pid_o[7] == !(hdr_pid_o[1] ^ hdr_pid_o[3] ^ hdr_pid_o[4] ^ hdr_pid_o[5]))
    else $error("parity bits of header wrong");
  pid_id_match_a: assert property ((s.state == LPS_ISSUE && next_s.state == LPS_SLOT) |=>
    hdr_valid_o && (s.b0.pid[5:0] == $past(s.ent.id) || s.b1.pid[5:0] == $past(s.ent.id)))
    else $error("header identifier does not match entry");
  diag_len_a: assert property ((hdr_valid_o && is_diag(hdr_pid_o[5:0])) |-> hdr_len_o == 4'h8)
    else $error("diagnostic frame not eight bytes");
  diag_classic_a: assert property ((hdr_valid_o && is_diag(hdr_pid_o[5:0])) |-> hdr_classic_o)
    else $error("diagnostic frame not classic checksum");
  no_reserved_a: assert property (hdr_valid_o |-> hdr_pid_o[5:1] != 5'h1F)
    else $error("reserved identifier issued");
  diag_pub_a: assert property ((hdr_valid_o && is_diag(hdr_pid_o[5:0])) |-> hdr_pub_o == !hdr_pid_o[0])
    else $error("diagnostic publisher wrong");
  table_hold_a: assert property ((s.state == LPS_SLOT && !advance) |=> $stable(active_table_o))
    else $error("table changed inside an entry");
  entry_order_a: assert property (($changed(entry_idx_o) && $past(s.state) != LPS_IDLE) |->
    entry_idx_o == 3'($past(entry_idx_o) + 3'h1) || entry_idx_o == 3'h0)
    else $error("entries out of order");
  slot_time_a: assert property ((s.state == LPS_SLOT && advance) |->
    slot_cycles == 32'(slot_len) * 32'(TICK_CYCLES) - 32'h1)
    else $error("slot length wrong");
  stall_hold_a: assert property ((hdr_valid_o && !hdr_ready_i) |=> hdr_valid_o && $stable(hdr_pid_o))
    else $error("header lost under stall");
  cks_first_a: assert property ((rx_valid_i && rx_first_i && next_s.cur_classic) |=> cks_o == ~$past(rx_byte_i))
    else $error("classic checksum start wrong");
endmodule

//--- lps_slave_model.sv
// far-side node model: takes headers, publishes data for slave frames
`timescale 1ns/100ps
module lps_slave_model
  import lps_pkg::*;
(
  input  wire logic       clk_i,         // system clock
  input  wire logic       reset_n_i,     // async reset, low
  input  wire logic       stall_i,       // hold off headers
  input  wire logic       hdr_valid_i,   // header waiting
  input  wire logic [7:0] hdr_pid_i,     // protected identifier
  input  wire logic [3:0] hdr_len_i,     // data byte count
  input  wire logic       hdr_pub_i,     // master publishes
  input  wire logic       hdr_classic_i, // classic checksum
  output logic            hdr_ready_o,   // header taken
  output logic            rx_valid_o,    // byte strobe
  output logic            rx_first_o,    // first byte
  output logic [7:0]      rx_byte_o      // data byte
);
  lps_hdr_type hq[$];
  int          tq[$];
  logic [7:0]  sent_q[$];
  int          cyc;
  int          left;
  int          idx;
  logic [7:0]  cur;
  assign hdr_ready_o = !stall_i && left == 0;
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cyc <= 0;
      left <= 0;
      idx <= 0;
      cur <= 8'h00;
      rx_valid_o <= 1'b0;
      rx_first_o <= 1'b0;
      rx_byte_o <= 8'hA5;
    end else begin
      cyc <= cyc + 1;
      rx_valid_o <= 1'b0;
      rx_first_o <= 1'b0;
      rx_byte_o <= ~rx_byte_o; // released line keeps moving
      if (hdr_valid_i && hdr_ready_o) begin
        hq.push_back('{hdr_classic_i, hdr_len_i, hdr_pub_i, hdr_pid_i});
        tq.push_back(cyc);
        cur <= hdr_pid_i;
        idx <= 0;
        left <= hdr_pub_i ? 0 : int'(hdr_len_i);
      end else if (left > 0) begin
        rx_valid_o <= 1'b1;
        rx_first_o <= idx == 0;
        rx_byte_o <= cur + 8'(idx * 19);
        sent_q.push_back(cur + 8'(idx * 19));
        idx <= idx + 1;
        left <= left - 1;
      end
    end
  end
endmodule

//--- lps_schedule_master_tb.sv
// self-checking bench of the schedule master
`timescale 1ns/100ps
module lps_schedule_master_tb;
  import lps_pkg::*;
  logic          clk_i = 1'b0;
  logic          reset_n_i = 1'b0;
  logic          run_i = 1'b0;
  logic          table_sel_i = 1'b0;
  logic          enhanced_i = 1'b0;
  logic          cfg_we_i = 1'b0;
  logic [3:0]    cfg_addr_i = 4'h0;
  lps_entry_type cfg_data_i = '0;
  logic          stall = 1'b0;
  logic          hdr_ready_i, hdr_valid_o, hdr_pub_o, hdr_classic_o, rx_valid_i, rx_first_i;
  logic          active_table_o, reserved_skip_o;
  logic [7:0]    hdr_pid_o, cks_o, rx_byte_i;
  logic [3:0]    hdr_len_o;
  logic [2:0]    entry_idx_o;
  int            err_count = 0;
  int            cmp_count = 0;
  int            skip_cnt = 0;

  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (reserved_skip_o === 1'b1) skip_cnt++;

  lps_schedule_master #(.TICK_CYCLES(4)) u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .run_i(run_i),
    .table_sel_i(table_sel_i), .enhanced_i(enhanced_i), .cfg_we_i(cfg_we_i), .cfg_addr_i(cfg_addr_i),
    .cfg_data_i(cfg_data_i), .hdr_ready_i(hdr_ready_i), .hdr_valid_o(hdr_valid_o), .hdr_pid_o(hdr_pid_o),
    .hdr_len_o(hdr_len_o), .hdr_pub_o(hdr_pub_o), .hdr_classic_o(hdr_classic_o), .rx_valid_i(rx_valid_i),
    .rx_first_i(rx_first_i), .rx_byte_i(rx_byte_i), .cks_o(cks_o), .active_table_o(active_table_o),
    .entry_idx_o(entry_idx_o), .reserved_skip_o(reserved_skip_o));
  lps_slave_model u_far (.clk_i(clk_i), .reset_n_i(reset_n_i), .stall_i(stall), .hdr_valid_i(hdr_valid_o),
    .hdr_pid_i(hdr_pid_o), .hdr_len_i(hdr_len_o), .hdr_pub_i(hdr_pub_o), .hdr_classic_i(hdr_classic_o),
    .hdr_ready_o(hdr_ready_i), .rx_valid_o(rx_valid_i), .rx_first_o(rx_first_i), .rx_byte_o(rx_byte_i));

  function automatic logic [7:0] pid_of(logic [5:0] i);
    return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
  endfunction
  function automatic logic [7:0] cks_of(logic [7:0] seed, int from, int n);
    logic [8:0] s;
    s = {1'b0, seed};
    for (int k = from; k < from + n; k++) begin
      s = s[7:0] + u_far.sent_q[k];
      s = s[7:0] + s[8];
    end
    return ~s[7:0];
  endfunction
  function automatic lps_entry_type ent(logic l, logic p, logic [5:0] i, logic [7:0] d, logic [3:0] n);
    return '{last: l, pub: p, len: n, id: i, dly: d};
  endfunction

  task automatic stop_test();
    if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, lps_entry_type e);
    @(posedge clk_i);
    cfg_we_i <= 1'b1;
    cfg_addr_i <= a;
    cfg_data_i <= e;
    @(posedge clk_i);
    cfg_we_i <= 1'b0;
  endtask
  task automatic go(logic sel);
    u_far.hq.delete();
    u_far.tq.delete();
    u_far.sent_q.delete();
    skip_cnt = 0;
    @(posedge clk_i);
    table_sel_i <= sel;
    run_i <= 1'b1;
  endtask
  task automatic collect(int n);
    for (int t = 0; t < 2000 && u_far.hq.size() < n; t++) @(posedge clk_i);
    chk("header count", u_far.hq.size(), n);
    run_i <= 1'b0;
    repeat (30) @(posedge clk_i);
  endtask
  task automatic wait_sent(int n);
    for (int t = 0; t < 500 && u_far.sent_q.size() < n; t++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
  endtask

  // diagnostic and reserved ids, forced fields, slot lengths
  task automatic t_sched();
    logic [7:0] ep[4] = '{8'h50, 8'h3C, 8'h7D, 8'h11};
    logic [3:0] el[4] = '{4'h4, 4'h8, 4'h8, 4'h2};
    logic [1:0] ef[4] = '{2'h2, 2'h3, 2'h1, 2'h2};
    wr(4'h0, ent(0, 1, 6'h10, 8'h00, 4'h4));
    wr(4'h1, ent(0, 0, 6'h3C, 8'h02, 4'h3));
    wr(4'h2, ent(0, 0, 6'h3F, 8'h05, 4'h1));
    wr(4'h3, ent(0, 0, 6'h3E, 8'h05, 4'h1));
    wr(4'h4, ent(0, 1, 6'h3D, 8'h02, 4'h2));
    wr(4'h5, ent(1, 1, 6'h11, 8'h00, 4'h2));
    enhanced_i <= 1'b1;
    go(1'b0);
    collect(4);
    for (int k = 0; k < 4; k++) begin
      chk("pid", u_far.hq[k].pid, ep[k]);
      chk("len", u_far.hq[k].len, el[k]);
      chk("pub classic", {u_far.hq[k].pub, u_far.hq[k].classic}, ef[k]);
    end
    chk("skips", skip_cnt, 2);
    chk("zero delay gap", u_far.tq[1] - u_far.tq[0], 7);
    chk("two tick gap", u_far.tq[3] - u_far.tq[2], 11);
  endtask

  // every identifier but 0x3E and 0x3F, eight per table pass, six in the last
  task automatic t_ids();
    int n;
    for (int g = 0; g < 8; g++) begin
      n = (g == 7) ? 6 : 8;
      for (int k = 0; k < 8; k++) wr(4'(k), ent(k == 7, 1'b1, 6'(g * 8 + k), 8'h00, 4'h1));
      go(1'b0);
      collect(n);
      for (int k = 0; k < n; k++) chk("pid", u_far.hq[k].pid, pid_of(6'(g * 8 + k)));
    end
  endtask

  // stalled consumer, table change asked for mid-table
  task automatic t_switch();
    logic [5:0] ids[4] = '{6'h01, 6'h02, 6'h21, 6'h22};
    for (int k = 0; k < 4; k++) wr({k[1], 2'b00, k[0]}, ent(k[0], 1, ids[k], 8'h00, 4'h1));
    stall <= 1'b1;
    go(1'b0);
    repeat (3) @(posedge clk_i);
    table_sel_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk("stalled valid", hdr_valid_o, 1'b1);
    chk("stalled pops", u_far.hq.size(), 0);
    chk("stalled index", entry_idx_o, 3'h0);
    chk("table after wrap", active_table_o, 1'b1);
    stall <= 1'b0;
    collect(4);
    for (int k = 0; k < 4; k++) chk("order", u_far.hq[k].pid, pid_of(ids[k]));
  endtask

  // published bytes summed: enhanced, diagnostic classic, then classic application
  task automatic t_cks();
    wr(4'h0, ent(0, 0, 6'h20, 8'h03, 4'h4));
    wr(4'h1, ent(1, 1, 6'h3D, 8'h03, 4'h2));
    enhanced_i <= 1'b1;
    go(1'b0);
    wait_sent(4);
    chk("app cks", cks_o, cks_of(pid_of(6'h20), 0, 4));
    wait_sent(12);
    chk("diag bytes", u_far.sent_q.size(), 12);
    chk("diag cks", cks_o, cks_of(8'h00, 4, 8));
    enhanced_i <= 1'b0;
    wait_sent(16);
    chk("classic app cks", cks_o, cks_of(8'h00, 12, 4));
    chk("classic app flag", u_far.hq[2].classic, 1'b1);
    collect(3);
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk("idle valid", hdr_valid_o, 1'b0);
    chk("idle table", active_table_o, 1'b0);
    chk("idle index", entry_idx_o, 3'h0);
    t_sched();
    t_ids();
    t_switch();
    t_cks();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    stop_test();
  end
endmodule
